// ---- logic/fbx_ascii_tx.sv ----
// Serial transmit shaper: passes bytes through or encodes them as ASCII frames.
`include "fbx_cfg.svh"
module fbx_ascii_tx import fbx_pkg::*; (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic ascii_en_in,
    input wire logic byte_valid_in,
    input wire logic [7:0] byte_in,
    input wire logic byte_last_in,
    output logic byte_ready_out,
    output logic char_valid_out,
    output logic [7:0] char_out,
    output logic char_last_out,
    input wire logic char_ready_in
);
    fbx_at_e st_q, st_d;
    logic valid_q, last_q;
    logic [7:0] char_q;
    logic [7:0] char_d;
    wire logic load = !valid_q || char_ready_in;
    wire logic tail = st_q == FBX_AT_CR || st_q == FBX_AT_LF;
    wire logic go = load && (ascii_en_in ? (tail || byte_valid_in) : byte_valid_in);

    assign byte_ready_out = load && (ascii_en_in ? st_q == FBX_AT_LO : 1'b1);
    assign char_valid_out = valid_q;
    assign char_out = char_q;
    assign char_last_out = last_q;

    // Each ASCII frame is a colon, two hex digits per byte, then CR LF.
    always_comb begin
        st_d = st_q;
        char_d = byte_in;
        if (ascii_en_in) begin
            unique case (st_q)
                FBX_AT_COLON: begin
                    char_d = `FBX_CH_COLON;
                    st_d = FBX_AT_HI;
                end
                FBX_AT_HI: begin
                    char_d = fbx_hex_char(byte_in[7:4]);
                    st_d = FBX_AT_LO;
                end
                FBX_AT_LO: begin
                    char_d = fbx_hex_char(byte_in[3:0]);
                    st_d = byte_last_in ? FBX_AT_CR : FBX_AT_HI;
                end
                FBX_AT_CR: begin
                    char_d = `FBX_CH_CR;
                    st_d = FBX_AT_LF;
                end
                FBX_AT_LF: begin
                    char_d = `FBX_CH_LF;
                    st_d = FBX_AT_COLON;
                end
                default: begin
                    char_d = `FBX_CH_LF;
                    st_d = FBX_AT_COLON;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            st_q <= FBX_AT_COLON;
            valid_q <= 1'b0;
            last_q <= 1'b0;
            char_q <= 8'h00;
        end else if (load) begin
            valid_q <= go;
            if (go) begin
                char_q <= char_d;
                last_q <= ascii_en_in ? st_q == FBX_AT_LF : byte_last_in;
                if (ascii_en_in) begin
                    st_q <= st_d;
                end
            end
        end
    end
endmodule

// ---- logic/fbx_cfg.svh ----
// Constants for the fieldbus buffer exchange framer: sizes, codes and reset values.
`ifndef FBX_CFG_SVH
`define FBX_CFG_SVH
`define FBX_BUF_DEPTH 64
`define FBX_REQ_SLOTS 24
`define FBX_REQ_IDX_W 5
`define FBX_ID_MIN 8'h01
`define FBX_ID_MAX 8'hf7
`define FBX_REQ_HDR 9'h003
`define FBX_FC_COIL_WR 8'h05
`define FBX_FC_REG_WR 8'h06
`define FBX_FC_COILS_WR 8'h0f
`define FBX_FC_REGS_WR 8'h10
`define FBX_CH_COLON 8'h3a
`define FBX_CH_CR 8'h0d
`define FBX_CH_LF 8'h0a
`define FBX_CH_DIGIT0 8'h30
`define FBX_CH_ALPHA_OFS 8'h37
`define FBX_CH_UPPER_A 8'h41
`define FBX_CH_UPPER_F 8'h46
`define FBX_CH_DIGIT9 8'h39
`define FBX_TRIG_RST 8'h00
`define FBX_LEN_RST 8'h00
`endif

// ---- logic/fbx_framer.sv ----
// Fieldbus buffer exchange framer: send decision, trigger and length bytes, swap, encapsulation.
// Operation
// - On-change mode sends only when the buffer differs from the last one sent.
// - On-trigger mode sends only when the trigger byte has changed.
// - With trigger mode on, each received telegram increments the delivered trigger byte.
// - With trigger mode on, byte zero of both buffers is the trigger byte.
// - With the length byte active, transmit exactly the count held in it; sending stops at the buffer end if the count runs past it.
// - With the length byte active, store the received character count in it.
// - Word swap exchanges the bytes of every 16-bit word in both directions.
// - ASCII variant keeps buffer handling but encodes serial frames as ASCII.
// - TCP encapsulation is allowed only together with the RTU slave protocol.
// - Forward serial master requests to the TCP server and return its responses.
// - Slave ID from both rotary switches is 1 to 247 and must match requests.
// - Dual-bus setup holds up to 24 requests sent over the encapsulation path.
// - Read function codes fill the input buffer; write codes take output data.
`include "fbx_cfg.svh"
module fbx_framer import fbx_pkg::*; #(
    parameter int DEPTH = `FBX_BUF_DEPTH,
    parameter int NREQ = `FBX_REQ_SLOTS,
    parameter int AW = $clog2(`FBX_BUF_DEPTH)
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic on_trigger_in,
    input wire logic trig_en_in,
    input wire logic len_en_in,
    input wire logic swap_in,
    input wire logic ascii_in,
    input wire logic encap_in,
    input wire logic dual_bus_in,
    input wire fbx_proto_e app_proto_in,
    input wire logic [3:0] slave_id_rotary_switch_a_in,
    input wire logic [3:0] slave_id_rotary_switch_b_in,
    output logic encap_active_out,
    output logic cfg_error_out,
    output logic id_error_out,
    input wire logic fb_wr_in,
    input wire logic [AW-1:0] fb_addr_in,
    input wire logic [7:0] fb_data_in,
    input wire logic fb_cycle_in,
    output logic [7:0] fb_rd_data_out,
    output logic send_busy_out,
    input wire logic rx_valid_in,
    input wire logic [7:0] rx_data_in,
    input wire logic rx_end_in,
    output logic ser_valid_out,
    output logic [7:0] ser_data_out,
    output logic ser_last_out,
    input wire logic ser_ready_in,
    output logic tcp_tx_valid_out,
    output logic [7:0] tcp_tx_data_out,
    output logic tcp_tx_end_out,
    input wire logic tcp_rx_valid_in,
    input wire logic [7:0] tcp_rx_data_in,
    input wire logic tcp_rx_last_in,
    output logic tcp_rx_ready_out,
    input wire logic tbl_wr_in,
    input wire logic [`FBX_REQ_IDX_W-1:0] tbl_idx_in,
    input wire logic [7:0] tbl_fc_in,
    input wire logic [AW-1:0] tbl_map_in,
    input wire logic [7:0] tbl_cnt_in,
    input wire logic req_go_in,
    input wire logic [`FBX_REQ_IDX_W-1:0] req_idx_in,
    output logic req_busy_out
);
    if (DEPTH < 4 || DEPTH > 256 || DEPTH != (1 << AW) || NREQ < 1 || NREQ > 32) begin
        $error("fbx_framer: unsupported DEPTH, AW or NREQ");
    end

    logic [7:0] out_buf [DEPTH];
    logic [7:0] shadow [DEPTH];
    logic [7:0] in_buf [DEPTH];
    logic [7:0] tbl_fc [NREQ];
    logic [AW-1:0] tbl_map [NREQ];
    logic [7:0] tbl_cnt [NREQ];
    logic [7:0] id_meta_q, slave_id_q, last_trig_q, in_trig_q, in_len_q, rx_cnt_q, rx_hi_q;
    logic snd_q, diff_q, rx_ph_q, rx_first_q, drop_q, tcp_end_q, tcp_valid_q;
    logic [7:0] tcp_data_q, fb_rd_q;
    logic [AW-1:0] snd_idx_q;
    logic [8:0] rq_k_q, rs_k_q, sent_n_q;
    logic [`FBX_REQ_IDX_W-1:0] rq_idx_q;
    fbx_rq_e rq_st_q;

    // Byte swap within each 16-bit word is a flip of the lowest address bit.
    function automatic logic [AW-1:0] fb_map(input logic [AW-1:0] a, input logic sw);
        return sw ? {a[AW-1:1], ~a[0]} : a;
    endfunction

    // Trigger byte at zero, length byte right after it, payload after both.
    wire logic [AW-1:0] len_pos = AW'(trig_en_in);
    wire logic [AW-1:0] pay_start = AW'(trig_en_in) + AW'(len_en_in);
    wire logic [8:0] pay_cnt = len_en_in ? {1'b0, out_buf[len_pos]} : 9'(DEPTH) - 9'(pay_start);
    wire logic [8:0] pay_end = 9'(pay_start) + pay_cnt;
    wire logic in_range = snd_idx_q >= pay_start && 9'(snd_idx_q) < pay_end;
    wire logic pay_last = 9'(snd_idx_q) + 9'h001 == pay_end;

    wire logic id_ok = slave_id_q >= `FBX_ID_MIN && slave_id_q <= `FBX_ID_MAX;
    wire logic encap_ok = encap_in && app_proto_in == FBX_PROTO_RTU_SLAVE;
    wire logic encap_act = encap_ok && id_ok;
    wire logic fwd_mode = encap_act && !dual_bus_in;
    wire logic tbl_mode = encap_act && dual_bus_in;
    assign encap_active_out = encap_act;
    assign cfg_error_out = encap_in && !encap_ok;
    assign id_error_out = encap_ok && !id_ok;

    wire logic trig_changed = out_buf[0] != last_trig_q;
    wire logic snd_go = fb_cycle_in && !snd_q && !fwd_mode &&
                        (on_trigger_in ? trig_changed : diff_q);
    wire logic byte_ready;
    wire logic snd_adv = snd_q && (!in_range || byte_ready);
    wire logic snd_done = snd_adv && snd_idx_q == AW'(DEPTH - 1);
    wire logic [AW-1:0] fb_waddr = fb_map(fb_addr_in, swap_in);
    wire logic fb_diff = fb_wr_in && fb_data_in != shadow[fb_waddr];

    // Receive decode: binary bytes pass through, ASCII pairs hex digits into bytes.
    wire logic [4:0] rx_hex = fbx_hex_val(rx_data_in);
    wire logic rx_colon = rx_valid_in && ascii_in && rx_data_in == `FBX_CH_COLON;
    wire logic rx_byte_v = ascii_in ? rx_valid_in && rx_hex[4] && rx_ph_q : rx_valid_in;
    wire logic [7:0] rx_byte = ascii_in ? {rx_hi_q[3:0], rx_hex[3:0]} : rx_data_in;
    wire logic rx_id_bad = rx_first_q && rx_byte != slave_id_q;

    // Request table slot in use and the response data it steers.
    wire logic [7:0] rq_fc = tbl_fc[rq_idx_q];
    wire logic [7:0] rq_cnt = tbl_cnt[rq_idx_q];
    wire logic rq_wr = fbx_fc_is_write(rq_fc);
    wire logic [8:0] rq_total = rq_wr ? `FBX_REQ_HDR + {1'b0, rq_cnt} : `FBX_REQ_HDR;
    wire logic [AW-1:0] rq_addr = tbl_map[rq_idx_q] + AW'(rq_k_q - `FBX_REQ_HDR);
    wire logic [AW-1:0] rs_addr = tbl_map[rq_idx_q] + AW'(rs_k_q - `FBX_REQ_HDR);
    wire logic rq_accept = tbl_mode && req_go_in && rq_st_q == FBX_RQ_IDLE &&
                           32'(req_idx_in) < NREQ;
    wire logic rs_take = rq_st_q == FBX_RQ_WAIT && tcp_rx_valid_in;
    wire logic rsp_wr = rs_take && !rq_wr && rs_k_q >= `FBX_REQ_HDR;
    wire logic [7:0] rq_byte = rq_k_q == 9'h000 ? slave_id_q :
                               rq_k_q == 9'h001 ? rq_fc :
                               rq_k_q == 9'h002 ? rq_cnt : out_buf[rq_addr];

    // Input buffer has one write port shared by serial receive and table responses.
    wire logic [8:0] rx_waddr = 9'(pay_start) + {1'b0, rx_cnt_q};
    wire logic ser_wr = rx_byte_v && !encap_act && rx_waddr < 9'(DEPTH);
    wire logic in_wr = ser_wr || rsp_wr;
    wire logic [AW-1:0] in_waddr = rsp_wr ? rs_addr : AW'(rx_waddr);
    wire logic [7:0] in_wdata = rsp_wr ? tcp_rx_data_in : rx_byte;
    wire logic rx_done = (rx_end_in && !encap_act) || (rs_take && tcp_rx_last_in);
    wire logic [7:0] len_val = rs_take ? rs_k_q[7:0] + 8'h01 : rx_cnt_q;

    wire logic [AW-1:0] rd_addr = fb_map(fb_addr_in, swap_in);
    wire logic [7:0] rd_view = (trig_en_in && rd_addr == '0) ? in_trig_q :
                               (len_en_in && rd_addr == len_pos) ? in_len_q : in_buf[rd_addr];

    wire logic sh_valid = fwd_mode ? tcp_rx_valid_in : snd_q && in_range;
    wire logic [7:0] sh_byte = fwd_mode ? tcp_rx_data_in : out_buf[snd_idx_q];
    wire logic sh_last = fwd_mode ? tcp_rx_last_in : pay_last;
    assign tcp_rx_ready_out = fwd_mode ? byte_ready : 1'b1;
    assign fb_rd_data_out = fb_rd_q;
    assign send_busy_out = snd_q;
    assign tcp_tx_valid_out = tcp_valid_q;
    assign tcp_tx_data_out = tcp_data_q;
    assign tcp_tx_end_out = tcp_end_q;
    assign req_busy_out = rq_st_q != FBX_RQ_IDLE;

    fbx_ascii_tx u_ascii_tx (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .ascii_en_in(ascii_in),
        .byte_valid_in(sh_valid),
        .byte_in(sh_byte),
        .byte_last_in(sh_last),
        .byte_ready_out(byte_ready),
        .char_valid_out(ser_valid_out),
        .char_out(ser_data_out),
        .char_last_out(ser_last_out),
        .char_ready_in(ser_ready_in)
    );

    // Buffers are small enough to live in flops, so they get a defined reset image.
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            for (int i = 0; i < DEPTH; i++) begin
                out_buf[i] <= 8'h00;
                shadow[i] <= 8'h00;
                in_buf[i] <= 8'h00;
            end
        end else begin
            if (fb_wr_in) out_buf[fb_waddr] <= fb_data_in;
            if (snd_adv) shadow[snd_idx_q] <= out_buf[snd_idx_q];
            if (in_wr) in_buf[in_waddr] <= in_wdata;
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            for (int i = 0; i < NREQ; i++) begin
                tbl_fc[i] <= 8'h00;
                tbl_map[i] <= '0;
                tbl_cnt[i] <= 8'h00;
            end
        end else if (tbl_wr_in && 32'(tbl_idx_in) < NREQ) begin
            tbl_fc[tbl_idx_in] <= tbl_fc_in;
            tbl_map[tbl_idx_in] <= tbl_map_in;
            tbl_cnt[tbl_idx_in] <= tbl_cnt_in;
        end
    end

    // The sender walks the whole buffer so the shadow copy stays complete.
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            snd_q <= 1'b0;
            snd_idx_q <= '0;
            diff_q <= 1'b0;
            last_trig_q <= `FBX_TRIG_RST;
        end else begin
            if (snd_go) begin
                snd_q <= 1'b1;
                snd_idx_q <= '0;
                last_trig_q <= out_buf[0];
            end else if (snd_adv) begin
                snd_idx_q <= snd_idx_q + AW'(1);
                if (snd_done) snd_q <= 1'b0;
            end
            // A differing write in the start cycle keeps the flag set.
            if (fb_diff) diff_q <= 1'b1;
            else if (snd_go) diff_q <= 1'b0;
        end
    end

    // The switches are asynchronous pins and pass two flops first.
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            id_meta_q <= 8'h00;
            slave_id_q <= 8'h00;
            fb_rd_q <= 8'h00;
        end else begin
            id_meta_q <= {slave_id_rotary_switch_a_in, slave_id_rotary_switch_b_in};
            slave_id_q <= id_meta_q;
            fb_rd_q <= rd_view;
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            rx_ph_q <= 1'b0;
            rx_hi_q <= 8'h00;
            rx_cnt_q <= 8'h00;
            rx_first_q <= 1'b1;
            drop_q <= 1'b0;
            in_trig_q <= `FBX_TRIG_RST;
            in_len_q <= `FBX_LEN_RST;
        end else begin
            if (rx_colon || rx_end_in) rx_ph_q <= 1'b0;
            else if (rx_valid_in && rx_hex[4]) begin
                rx_ph_q <= ~rx_ph_q;
                rx_hi_q <= {4'h0, rx_hex[3:0]};
            end
            if (rx_end_in) begin
                rx_cnt_q <= 8'h00;
                rx_first_q <= 1'b1;
            end else if (rx_byte_v) begin
                if (rx_cnt_q != 8'hff) rx_cnt_q <= rx_cnt_q + 8'h01;
                rx_first_q <= 1'b0;
                if (rx_first_q) drop_q <= rx_id_bad;
            end
            // Plain 8-bit add, so 255 rolls to zero and still reads as a change.
            if (rx_done && trig_en_in) in_trig_q <= in_trig_q + 8'h01;
            if (rx_done && len_en_in) in_len_q <= len_val;
        end
    end

    // Encapsulation: forwarded master requests and table requests go out on TCP.
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            tcp_valid_q <= 1'b0;
            tcp_data_q <= 8'h00;
            tcp_end_q <= 1'b0;
            rq_st_q <= FBX_RQ_IDLE;
            rq_idx_q <= '0;
            rq_k_q <= 9'h000;
            rs_k_q <= 9'h000;
        end else begin
            tcp_valid_q <= 1'b0;
            tcp_end_q <= 1'b0;
            if (fwd_mode) begin
                tcp_valid_q <= rx_byte_v && (rx_first_q ? !rx_id_bad : !drop_q);
                tcp_data_q <= rx_byte;
                tcp_end_q <= rx_end_in && !drop_q && !rx_first_q;
            end
            unique case (rq_st_q)
                FBX_RQ_IDLE: if (rq_accept) begin
                    rq_st_q <= FBX_RQ_SEND;
                    rq_idx_q <= req_idx_in;
                    rq_k_q <= 9'h000;
                end
                FBX_RQ_SEND: begin
                    tcp_valid_q <= 1'b1;
                    tcp_data_q <= rq_byte;
                    rq_k_q <= rq_k_q + 9'h001;
                    if (rq_k_q + 9'h001 == rq_total) begin
                        rq_st_q <= FBX_RQ_WAIT;
                        rs_k_q <= 9'h000;
                    end
                end
                FBX_RQ_WAIT: if (rs_take) begin
                    rs_k_q <= rs_k_q + 9'h001;
                    if (tcp_rx_last_in) rq_st_q <= FBX_RQ_IDLE;
                end
                default: rq_st_q <= FBX_RQ_IDLE;
            endcase
            if (rq_st_q == FBX_RQ_SEND && rq_k_q + 9'h001 == rq_total) tcp_end_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) sent_n_q <= 9'h000;
        else if (snd_go) sent_n_q <= 9'h000;
        else if (snd_q && in_range && byte_ready) sent_n_q <= sent_n_q + 9'h001;
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);
    property p_on_change;
        snd_go && !on_trigger_in |-> diff_q;
    endproperty
    a_on_change: assert property (p_on_change) else $error("send without change");
    property p_trig_only;
        on_trigger_in && fb_cycle_in && !snd_q && !trig_changed |=> !snd_q;
    endproperty
    a_trig_only: assert property (p_trig_only) else $error("send w/o trigger");
    property p_trig_inc;
        rx_done && trig_en_in |=> in_trig_q == 8'($past(in_trig_q) + 8'h01);
    endproperty
    a_trig_inc: assert property (p_trig_inc) else $error("trigger not bumped");
    property p_len_tx;
        $fell(snd_q) && len_en_in && $past(pay_end) <= 9'(DEPTH) |-> sent_n_q == $past(pay_cnt);
    endproperty
    a_len_tx: assert property (p_len_tx) else $error("sent count differs");
    property p_len_rx;
        rx_done && len_en_in |=> in_len_q == $past(len_val);
    endproperty
    a_len_rx: assert property (p_len_rx) else $error("length byte wrong");
    property p_swap;
        swap_in && fb_wr_in && fb_addr_in == '0 |=> out_buf[1] == $past(fb_data_in);
    endproperty
    a_swap: assert property (p_swap) else $error("word swap missing");
    property p_encap;
        encap_active_out |-> app_proto_in == FBX_PROTO_RTU_SLAVE && !cfg_error_out;
    endproperty
    a_encap: assert property (p_encap) else $error("bad encapsulation");
    property p_fwd_rsp;
        fwd_mode && tcp_rx_valid_in && tcp_rx_ready_out |=> ser_valid_out;
    endproperty
    a_fwd_rsp: assert property (p_fwd_rsp) else $error("response not returned");
    property p_id_drop;
        fwd_mode && rx_byte_v && rx_id_bad |=> !tcp_tx_valid_out;
    endproperty
    a_id_drop: assert property (p_id_drop) else $error("foreign ID forwarded");
    property p_tbl_go;
        rq_accept |=> req_busy_out ##1 tcp_tx_valid_out && tcp_tx_data_out == slave_id_q;
    endproperty
    a_tbl_go: assert property (p_tbl_go) else $error("request not issued");
    property p_rsp_dir;
        rsp_wr |-> !fbx_fc_is_write(rq_fc) && rq_st_q == FBX_RQ_WAIT;
    endproperty
    a_rsp_dir: assert property (p_rsp_dir) else $error("write FC stored data");
    c_trig_send: cover property (on_trigger_in && snd_go);
    c_rx_done: cover property (rx_done && trig_en_in && in_trig_q == 8'hff);
    c_tbl_rsp: cover property (rsp_wr && tcp_rx_last_in);
    c_fwd: cover property (fwd_mode && tcp_tx_end_out);
endmodule

// ---- logic/fbx_pkg.sv ----
// Types and shared helper functions of the fieldbus buffer exchange framer.
package fbx_pkg;
`include "fbx_cfg.svh"
    typedef enum logic [1:0] {
        FBX_PROTO_RTU_SLAVE = 2'b00,
        FBX_PROTO_RTU_MASTER = 2'b01,
        FBX_PROTO_TRANSPARENT = 2'b11,
        FBX_PROTO_OTHER = 2'b10
    } fbx_proto_e;
    typedef enum logic [2:0] {
        FBX_AT_COLON = 3'b000,
        FBX_AT_HI = 3'b001,
        FBX_AT_LO = 3'b011,
        FBX_AT_CR = 3'b010,
        FBX_AT_LF = 3'b110
    } fbx_at_e;
    typedef enum logic [1:0] {
        FBX_RQ_IDLE = 2'b00,
        FBX_RQ_SEND = 2'b01,
        FBX_RQ_WAIT = 2'b11
    } fbx_rq_e;

    function automatic logic fbx_fc_is_write(input logic [7:0] fc);
        return fc == `FBX_FC_COIL_WR || fc == `FBX_FC_REG_WR ||
               fc == `FBX_FC_COILS_WR || fc == `FBX_FC_REGS_WR;
    endfunction

    function automatic logic [7:0] fbx_hex_char(input logic [3:0] n);
        return (n < 4'ha) ? (`FBX_CH_DIGIT0 + {4'h0, n}) : (`FBX_CH_ALPHA_OFS + {4'h0, n});
    endfunction

    // Returns {valid, nibble}; only upper-case hex digits are accepted.
    function automatic logic [4:0] fbx_hex_val(input logic [7:0] c);
        logic [7:0] t;
        t = 8'h00;
        if (c >= `FBX_CH_DIGIT0 && c <= `FBX_CH_DIGIT9) begin
            t = c - `FBX_CH_DIGIT0;
            return {1'b1, t[3:0]};
        end
        if (c >= `FBX_CH_UPPER_A && c <= `FBX_CH_UPPER_F) begin
            t = c - `FBX_CH_ALPHA_OFS;
            return {1'b1, t[3:0]};
        end
        return 5'h00;
    endfunction
endpackage

// ---- testbench/fbx_ser_sink.sv ----
// Serial-side partner model that takes framer bytes and can stall every other cycle.
module fbx_ser_sink (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic slow_in,
    input wire logic valid_in,
    input wire logic [7:0] data_in,
    input wire logic last_in,
    output logic ready_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] got[$];
    int lasts;
    logic ph_q;
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) ph_q <= 1'b0;
        else ph_q <= ~ph_q;
    end
    // A slow receiver exercises the sender's hold-until-ready path.
    assign ready_out = ~slow_in | ph_q;
    always @(posedge clk_in) begin
        if (valid_in && ready_out) begin
            got.push_back(data_in);
            if (last_in) lasts++;
        end
    end
endmodule

// ---- testbench/fieldbus_buffer_exchange_framer_tb_top.sv ----
// Self-checking bench for the buffer exchange framer.
module fieldbus_buffer_exchange_framer_tb_top;
    import fbx_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_in = 0, reset_in = 1, on_trig = 1, trig_en = 1, len_en = 1, slow = 1;
    logic swap = 0, ascii = 0, dual = 0, encap = 0, fb_wr = 0, fb_cycle = 0;
    logic rx_v = 0, rx_e = 0, zero = 0, busy, ser_v, ser_l, ser_r, act, cfg_err, id_err;
    logic tx_v, tx_e, trdy, tv = 0;
    logic [7:0] tx_d, td = 8'h00, tq[$];
    logic [5:0] fb_addr = 6'h00;
    logic [7:0] fb_data = 8'h00, rx_d = 8'h00, rd, ser_d, p[6], r0;
    logic [3:0] sw_a = 4'h0, sw_b = 4'h0;
    fbx_proto_e proto = FBX_PROTO_RTU_SLAVE;
    int err_total, samples_checked, seed = 41737, te;
    always #10 clk_in = ~clk_in;
    // Collects every byte the framer pushes towards the TCP server.
    always @(posedge clk_in) begin
        if (tx_v) tq.push_back(tx_d);
        if (tx_e) te++;
    end
    fbx_framer fbx_framer_inst (.clk_in(clk_in), .reset_in(reset_in), .on_trigger_in(on_trig),
        .trig_en_in(trig_en), .len_en_in(len_en), .swap_in(swap), .ascii_in(ascii),
        .encap_in(encap), .dual_bus_in(dual), .app_proto_in(proto),
        .slave_id_rotary_switch_a_in(sw_a), .slave_id_rotary_switch_b_in(sw_b),
        .encap_active_out(act), .cfg_error_out(cfg_err), .id_error_out(id_err),
        .fb_wr_in(fb_wr), .fb_addr_in(fb_addr), .fb_data_in(fb_data), .fb_cycle_in(fb_cycle),
        .fb_rd_data_out(rd), .send_busy_out(busy), .rx_valid_in(rx_v), .rx_data_in(rx_d),
        .rx_end_in(rx_e), .ser_valid_out(ser_v), .ser_data_out(ser_d), .ser_last_out(ser_l),
        .ser_ready_in(ser_r), .tcp_tx_valid_out(tx_v), .tcp_tx_data_out(tx_d),
        .tcp_tx_end_out(tx_e), .tcp_rx_valid_in(tv), .tcp_rx_data_in(td), .tcp_rx_last_in(tv),
        .tcp_rx_ready_out(trdy), .tbl_wr_in(zero), .tbl_idx_in(5'h00), .tbl_fc_in(8'h00),
        .tbl_map_in(6'h00), .tbl_cnt_in(8'h00), .req_go_in(zero), .req_idx_in(5'h00),
        .req_busy_out());
    fbx_ser_sink fbx_ser_sink_inst (.clk_in(clk_in), .reset_in(reset_in), .slow_in(slow),
        .valid_in(ser_v), .data_in(ser_d), .last_in(ser_l), .ready_out(ser_r));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk_in);
        fb_wr <= 1'b1;
        fb_addr <= a;
        fb_data <= d;
        @(posedge clk_in);
        fb_wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
        @(posedge clk_in);
        fb_addr <= a;
        repeat (2) @(posedge clk_in);
        #1 chk(rd, exp);
    endtask
    task automatic rx(input logic [7:0] d, input logic v, input logic e);
        @(posedge clk_in);
        rx_v <= v;
        rx_d <= d;
        rx_e <= e;
    endtask
    // Fires one cycle-end and checks how many bytes, and which, leave the serial side.
    task automatic send(input int n);
        fbx_ser_sink_inst.got.delete();
        fbx_ser_sink_inst.lasts = 0;
        @(posedge clk_in);
        fb_cycle <= 1'b1;
        @(posedge clk_in);
        fb_cycle <= 1'b0;
        for (int i = 0; i < 400 && (i < 3 || busy !== 1'b0); i++) @(posedge clk_in);
        chk(8'(fbx_ser_sink_inst.got.size()), 8'(n));
        chk(8'(fbx_ser_sink_inst.lasts), 8'(n > 0));
        for (int j = 0; j < n; j++) chk(fbx_ser_sink_inst.got[j], p[2+j]);
    endtask
    task automatic summarize;
        $display("errors %0d checks %0d", err_total, samples_checked);
        if (err_total == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        #1ms;
        err_total++;
        summarize();
    end
    initial begin
        repeat (2) @(posedge clk_in);
        reset_in <= 1'b0;
        for (int k = 2; k < 6; k++) begin
            p[k] = $random(seed);
            wr(6'(k), p[k]);
        end
        wr(6'h01, 8'h03);
        wr(6'h00, 8'h01);
        send(3);
        slow <= 1'b0;
        p[2] = $random(seed);
        wr(6'h02, p[2]);
        send(0);
        wr(6'h00, 8'hff);
        send(3);
        on_trig <= 1'b0;
        send(0);
        p[3] = ~p[3];
        wr(6'h03, p[3]);
        send(3);
        r0 = $random(seed);
        rx(r0, 1'b1, 1'b0);
        rx(8'h00, 1'b0, 1'b0);
        rx(8'h00, 1'b0, 1'b1);
        rx(8'h00, 1'b0, 1'b0);
        rd_chk(6'h00, 8'h01);
        rd_chk(6'h01, 8'h01);
        rd_chk(6'h02, r0);
        for (int t = 0; t < 254; t++) rx(8'h00, 1'b0, t[0] == 1'b0);
        rx(8'h00, 1'b0, 1'b1);
        rx(8'h00, 1'b0, 1'b0);
        rd_chk(6'h00, 8'h81);
        for (int t = 0; t < 127; t++) begin
            rx(8'h00, 1'b0, 1'b1);
            rx(8'h00, 1'b0, 1'b0);
        end
        rd_chk(6'h00, 8'h00);
        swap <= 1'b1;
        wr(6'h00, 8'h02);
        rd_chk(6'h03, r0);
        encap <= 1'b1;
        proto <= FBX_PROTO_OTHER;
        repeat (3) @(posedge clk_in);
        chk({act, cfg_err, id_err}, 8'h02);
        proto <= FBX_PROTO_RTU_SLAVE;
        repeat (4) @(posedge clk_in);
        chk({act, cfg_err, id_err}, 8'h01);
        sw_a <= 4'hf;
        sw_b <= 4'h7;
        repeat (4) @(posedge clk_in);
        chk({act, cfg_err, id_err}, 8'h04);
        sw_b <= 4'h8;
        repeat (4) @(posedge clk_in);
        chk({act, cfg_err, id_err}, 8'h01);
        sw_b <= 4'h7;
        repeat (4) @(posedge clk_in);
        r0 = $random(seed);
        // The first telegram carries a foreign ID and must not reach the TCP side.
        for (int g = 0; g < 2; g++) begin
            rx(g ? 8'hf7 : 8'h01, 1'b1, 1'b0);
            rx(r0, 1'b1, 1'b0);
            rx(8'h00, 1'b0, 1'b1);
            rx(8'h00, 1'b0, 1'b0);
        end
        fbx_ser_sink_inst.got.delete();
        td <= r0 ^ 8'h5a;
        tv <= 1'b1;
        @(posedge clk_in);
        while (trdy !== 1'b1) @(posedge clk_in);
        tv <= 1'b0;
        repeat (3) @(posedge clk_in);
        chk(8'(tq.size()), 8'h02);
        chk(tq[0], 8'hf7);
        chk(tq[1], r0);
        chk(8'(te), 8'h01);
        chk(8'(fbx_ser_sink_inst.got.size()), 8'h01);
        chk(fbx_ser_sink_inst.got[0], r0 ^ 8'h5a);
        summarize();
    end
endmodule
